// ==== isoa_core.sv ====
// Two-wire slave byte engine with shift-data and own-address registers.
// Operation
// (RULE_01) One register shifts bytes out and in.
// (RULE_02) Writing during wait releases clock, starts shifting.
// (RULE_03) Reset clears the shift register.
// (RULE_04) Software never writes during a byte transfer.
// (RULE_05) Software accesses shift data only while waiting.
// (RULE_06) Master may write once after start trigger.
// (RULE_07) Reserved transfer writes after stop interrupt.
// (RULE_08) Own address holds seven bits, MSB first.
// (RULE_09) Own address bit zero always reads zero.
// (RULE_10) Own address unchanged while start detected; not enforced, a write to OFS_OWN_ADDR lands even while std_reg is set.
// (RULE_11) Reset clears the own address register.
// (RULE_12) Match flag sets at eighth clock rise.
// (RULE_13) Transmit waits released by data write only.
// (RULE_14) Wait state holds the clock line low.
`timescale 1ns/100ps
module isoa_core
	import isoa_pkg::*;
(
	input  wire logic                  sys_clk_i,   // System clock.
	input  wire logic                  rst_n_i,     // Async reset, low.
	input  wire logic [REG_ADDR_W-1:0] reg_addr_i,  // Register address.
	input  wire logic [REG_DATA_W-1:0] reg_wdata_i, // Write data.
	input  wire logic                  reg_wr_i,    // Write strobe.
	input  wire logic                  reg_rd_i,    // Read strobe.
	output logic      [REG_DATA_W-1:0] reg_rdata_o, // Read data.
	input  wire logic                  scl_i,       // Clock pin in.
	output logic                       scl_o,       // Clock pin out.
	output logic                       scl_oe_o,    // Clock pin enable.
	input  wire logic                  sda_i,       // Data pin in.
	output logic                       sda_o,       // Data pin out.
	output logic                       sda_oe_o,    // Data pin enable.
	output logic                       irq_o        // Interrupt level.
);
	// Address compare shared by every register decode.
	function automatic logic is_reg(input logic [REG_ADDR_W-1:0] a,
		input logic [REG_ADDR_W-1:0] ofs);
		is_reg = (a == ofs);
	endfunction

	// Synchronised link view.
	logic scl_lvl;       // Clock level.
	logic sda_lvl;       // Data level.
	logic scl_rise;      // Clock rise pulse.
	logic scl_fall;      // Clock fall pulse.
	logic bus_start;     // Start pulse.
	logic bus_stop;      // Stop pulse.

	// Byte engine state.
	isoa_state_t state_reg;        // Current state.
	isoa_state_t state_next;       // Next state.
	logic [7:0]  shift_reg;        // Byte shifter.
	logic [7:0]  shift_next;       // Next shifter.
	logic [3:0]  cnt_reg;          // Bits moved in this byte.
	logic [3:0]  cnt_next;         // Next bit count.
	logic        sda_low_reg;      // Pull data low.
	logic        sda_low_next;     // Next pull.
	logic        addr_phase_reg;   // First byte after start.
	logic        addr_phase_next;  // Next phase.
	logic        xmit_reg;         // Transmit state flag.
	logic        xmit_next;        // Next transmit flag.
	logic        match_reg;        // Address match flag.
	logic        match_next;       // Next match flag.
	logic        std_reg;          // Start detected flag.
	logic        std_next;         // Next start flag.
	logic [7:0]  ev_vec;           // Event pulses this cycle.

	// Register file state.
	logic [7:1]  own_addr_reg;     // Seven address bits.
	logic [7:1]  own_addr_next;    // Next address.
	logic [7:0]  irq_mask_reg;     // Interrupt mask.
	logic [7:0]  irq_mask_next;    // Next mask.
	logic [7:0]  irq_status_reg;   // Sticky events.
	logic [7:0]  irq_status_next;  // Next events.
	logic [7:0]  rdata_reg;        // Read data.
	logic [7:0]  rdata_next;       // Next read data.

	// Decoded accesses.
	logic        sw_write;         // Shift data written.
	logic        cancel_wr;        // Wait cancel bit written.
	logic [7:0]  rx_byte;          // Shifter after this bit.
	logic [7:0]  flags;            // Live flag view.

	isoa_pin_sync u_sync (
		.sys_clk_i  (sys_clk_i),
		.rst_n_i    (rst_n_i),
		.scl_i      (scl_i),
		.sda_i      (sda_i),
		.scl_lvl_o  (scl_lvl),
		.sda_lvl_o  (sda_lvl),
		.scl_rise_o (scl_rise),
		.scl_fall_o (scl_fall),
		.start_o    (bus_start),
		.stop_o     (bus_stop)
	);

	assign sw_write  = reg_wr_i & is_reg(reg_addr_i, OFS_SHIFT_DATA);
	assign cancel_wr = reg_wr_i & is_reg(reg_addr_i, OFS_CONTROL) &
		reg_wdata_i[CTL_WAIT_CANCEL_BIT];
	assign rx_byte   = {shift_reg[6:0], sda_lvl};

	// Next-state logic of the byte engine. A stop or start overrides any
	// byte in flight, since the master owns the framing.
	always_comb begin
		state_next      = state_reg;
		shift_next      = shift_reg;
		cnt_next        = cnt_reg;
		sda_low_next    = sda_low_reg;
		addr_phase_next = addr_phase_reg;
		xmit_next       = xmit_reg;
		match_next      = match_reg;
		std_next        = std_reg;
		ev_vec          = 8'h00;
		if (bus_stop) begin
			// Stop ends everything and frees both lines.
			state_next   = ST_IDLE;
			sda_low_next = 1'b0;
			xmit_next    = 1'b0;
			match_next   = 1'b0;
			std_next     = 1'b0;
			ev_vec[IRQ_STOP] = 1'b1;
		end else if (bus_start) begin
			// Start (or restart) opens an address byte.
			state_next      = ST_SHIFT;
			cnt_next        = 4'h0;
			addr_phase_next = 1'b1;
			sda_low_next    = 1'b0;
			xmit_next       = 1'b0;
			match_next      = 1'b0;
			std_next        = 1'b1;
			ev_vec[IRQ_START] = 1'b1;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					// Preloading while the bus is quiet is harmless.
					if (sw_write) begin
						shift_next = reg_wdata_i;
					end
				end
				ST_SHIFT: begin
					if (scl_rise && cnt_reg < BITS_PER_BYTE) begin
						// Both directions sample the line, so a sent byte
						// reads back as what the bus really carried.
						shift_next = rx_byte; // RULE_01
						cnt_next   = cnt_reg + 4'h1;
						if (addr_phase_reg &&
							cnt_reg == BITS_PER_BYTE - 4'h1) begin
							if (rx_byte[7:1] == own_addr_reg) begin
								match_next = 1'b1; // RULE_12
								xmit_next  = rx_byte[0];
								ev_vec[IRQ_MATCH] = 1'b1;
							end else begin
								// Not us: drop out until the next start.
								state_next = ST_IDLE;
							end
						end
					end else if (scl_fall && cnt_reg < BITS_PER_BYTE) begin
						// Next bit goes out while the clock is low.
						sda_low_next = xmit_reg & ~addr_phase_reg &
							~shift_reg[7]; // RULE_01
					end else if (scl_fall) begin
						// Acknowledge our address and every received byte.
						state_next   = ST_ACK;
						sda_low_next = addr_phase_reg | ~xmit_reg;
					end
				end
				ST_ACK: begin
					if (scl_rise && xmit_reg && !addr_phase_reg &&
						sda_lvl) begin
						// Master refused more data: leave the bus alone.
						state_next = ST_IDLE;
						xmit_next  = 1'b0;
					end else if (scl_fall) begin
						state_next      = ST_WAIT; // RULE_14
						sda_low_next    = 1'b0;
						addr_phase_next = 1'b0;
						ev_vec[IRQ_BYTE_DONE] = 1'b1;
					end
				end
				ST_WAIT: begin
					if (sw_write) begin
						// New byte ends the wait and starts shifting.
						state_next   = ST_SHIFT; // RULE_02
						shift_next   = reg_wdata_i;
						cnt_next     = 4'h0;
						sda_low_next = xmit_reg & ~reg_wdata_i[7];
					end else if (cancel_wr && !xmit_reg) begin
						// Receive side may resume without new data.
						state_next = ST_SHIFT;
						cnt_next   = 4'h0;
					end
				end
			endcase
		end
	end

	// Byte engine registers.
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg      <= ST_IDLE;
			shift_reg      <= RST_SHIFT_DATA; // RULE_03
			cnt_reg        <= 4'h0;
			sda_low_reg    <= 1'b0;
			addr_phase_reg <= 1'b0;
			xmit_reg       <= 1'b0;
			match_reg      <= 1'b0;
			std_reg        <= 1'b0;
		end else begin
			state_reg      <= state_next;
			shift_reg      <= shift_next;
			cnt_reg        <= cnt_next;
			sda_low_reg    <= sda_low_next;
			addr_phase_reg <= addr_phase_next;
			xmit_reg       <= xmit_next;
			match_reg      <= match_next;
			std_reg        <= std_next;
		end
	end

	assign flags = {4'h0, state_reg == ST_WAIT, xmit_reg, match_reg,
		std_reg};

	// Register file next values. A status read clears the events it
	// returned, but an event in the same cycle still lands.
	always_comb begin
		own_addr_next   = own_addr_reg;
		irq_mask_next   = irq_mask_reg;
		irq_status_next = (reg_rd_i && is_reg(reg_addr_i, OFS_IRQ_STATUS)) ?
			RST_IRQ_STATUS : irq_status_reg;
		irq_status_next = irq_status_next | ev_vec;
		rdata_next      = 8'h00;
		if (reg_wr_i && is_reg(reg_addr_i, OFS_OWN_ADDR)) begin
			// Bit zero has no storage.
			own_addr_next = reg_wdata_i[7:1]; // RULE_08
		end
		if (reg_wr_i && is_reg(reg_addr_i, OFS_IRQ_MASK)) begin
			irq_mask_next = reg_wdata_i;
		end
		if (reg_rd_i) begin
			// Unmapped addresses read as zero.
			if (is_reg(reg_addr_i, OFS_SHIFT_DATA)) begin
				rdata_next = shift_reg;
			end else if (is_reg(reg_addr_i, OFS_OWN_ADDR)) begin
				rdata_next = {own_addr_reg, 1'b0}; // RULE_09
			end else if (is_reg(reg_addr_i, OFS_IRQ_STATUS)) begin
				rdata_next = irq_status_reg;
			end else if (is_reg(reg_addr_i, OFS_IRQ_MASK)) begin
				rdata_next = irq_mask_reg;
			end else if (is_reg(reg_addr_i, OFS_FLAGS)) begin
				rdata_next = flags;
			end
		end
	end

	// Register file registers.
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			own_addr_reg   <= RST_OWN_ADDR[7:1]; // RULE_11
			irq_mask_reg   <= RST_IRQ_MASK;
			irq_status_reg <= RST_IRQ_STATUS;
			rdata_reg      <= 8'h00;
		end else begin
			own_addr_reg   <= own_addr_next;
			irq_mask_reg   <= irq_mask_next;
			irq_status_reg <= irq_status_next;
			rdata_reg      <= rdata_next;
		end
	end

	// Open-drain pins: only ever pull low.
	assign scl_o       = 1'b0;
	assign sda_o       = 1'b0;
	assign scl_oe_o    = (state_reg == ST_WAIT); // RULE_14
	assign sda_oe_o    = sda_low_reg;
	assign reg_rdata_o = rdata_reg;
	assign irq_o       = |(irq_status_reg & irq_mask_reg);

	// Checks on the design's own behaviour.
	logic quiet;   // No bus condition this cycle.
	assign quiet = ~bus_start & ~bus_stop;

	property p_shift_reset;
		@(posedge sys_clk_i) $rose(rst_n_i) |-> shift_reg == 8'h00;
	endproperty
	a_shift_reset: assert property (p_shift_reset) // RULE_03
		else $error("Shift data not cleared by reset.");

	property p_addr_reset;
		@(posedge sys_clk_i) $rose(rst_n_i) |-> own_addr_reg == 7'h00;
	endproperty
	a_addr_reset: assert property (p_addr_reset) // RULE_11
		else $error("Own address not cleared by reset.");

	property p_shift_bit;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(state_reg == ST_SHIFT && scl_rise && cnt_reg < 4'h8 && quiet)
		|=> shift_reg == {$past(shift_reg[6:0]), $past(sda_lvl)} &&
			cnt_reg == $past(cnt_reg) + 4'h1;
	endproperty
	a_shift_bit: assert property (p_shift_bit) // RULE_01
		else $error("Clock rise did not shift one bit in.");

	sequence s_wait_write;
		state_reg == ST_WAIT && sw_write && quiet;
	endsequence
	property p_wait_release;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_wait_write |=> state_reg == ST_SHIFT && !scl_oe_o &&
			shift_reg == $past(reg_wdata_i) && cnt_reg == 4'h0;
	endproperty
	a_wait_release: assert property (p_wait_release) // RULE_02
		else $error("Write in wait did not release and load.");

	sequence s_eighth_hit;
		state_reg == ST_SHIFT && addr_phase_reg && scl_rise &&
		cnt_reg == 4'h7 && quiet && rx_byte[7:1] == own_addr_reg;
	endsequence
	property p_match_set;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_eighth_hit |=> match_reg && irq_status_reg[IRQ_MATCH] &&
			xmit_reg == $past(sda_lvl);
	endproperty
	a_match_set: assert property (p_match_set) // RULE_12
		else $error("Address match not flagged at eighth rise.");

	property p_match_miss;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(state_reg == ST_SHIFT && addr_phase_reg && scl_rise &&
		cnt_reg == 4'h7 && quiet && rx_byte[7:1] != own_addr_reg)
		|=> state_reg == ST_IDLE && !match_reg;
	endproperty
	a_match_miss: assert property (p_match_miss) // RULE_08
		else $error("Foreign address was not ignored.");

	property p_bit0_zero;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		(reg_rd_i && reg_addr_i == OFS_OWN_ADDR) |=>
			reg_rdata_o == {$past(own_addr_reg), 1'b0};
	endproperty
	a_bit0_zero: assert property (p_bit0_zero) // RULE_09
		else $error("Own address read back wrong or bit zero set.");

	sequence s_ninth_end;
		state_reg == ST_ACK && scl_fall && quiet;
	endsequence
	property p_wait_hold;
		@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_ninth_end |=> scl_oe_o && !sda_oe_o &&
			irq_status_reg[IRQ_BYTE_DONE];
	endproperty
	a_wait_hold: assert property (p_wait_hold) // RULE_14
		else $error("Ninth clock fall did not hold the clock low.");

endmodule

// ==== isoa_core_tb_top.sv ====
// Self-checking bench for the shift-data and own-address block.
`timescale 1ns/100ps
module isoa_core_tb_top
	import isoa_pkg::*;
;
	logic        clk    = 1'b0;     // System clock.
	logic        rst_n  = 1'b0;     // Reset, active low.
	logic [15:0] addr   = 16'h0000; // Register address.
	logic [7:0]  wdata  = 8'h00;    // Write data.
	logic        wr     = 1'b0;     // Write strobe.
	logic        rd     = 1'b0;     // Read strobe.
	logic [7:0]  rdata;             // Read data.
	logic        scl_oe;            // Device holds the clock low.
	logic        sda_oe;            // Device pulls the data low.
	logic        irq;               // Interrupt level.
	logic        m_scl;             // Master pulls the clock low.
	logic        m_sda;             // Master pulls the data low.
	logic        m_stall;           // Master gave up on a stretch.
	logic        scl_out;           // Clock level driven while enabled.
	logic        sda_out;           // Data level driven while enabled.
	// Open-drain pads: the pull-up wins unless someone drives the line,
	// so a wrong driven level would show up on the bus.
	wire         scl_ln = ~m_scl & (scl_oe ? scl_out : 1'b1);
	wire         sda_ln = ~m_sda & (sda_oe ? sda_out : 1'b1);
	int          n_errors    = 0;   // Mismatches seen.
	int          check_count = 0;   // Comparisons made.

	// Clock of 4 ns.
	always #2 clk = ~clk;

	isoa_core isoa_core_inst (
		.sys_clk_i  (clk),
		.rst_n_i    (rst_n),
		.reg_addr_i (addr),
		.reg_wdata_i(wdata),
		.reg_wr_i   (wr),
		.reg_rd_i   (rd),
		.reg_rdata_o(rdata),
		.scl_i      (scl_ln),
		.scl_o      (scl_out),
		.scl_oe_o   (scl_oe),
		.sda_i      (sda_ln),
		.sda_o      (sda_out),
		.sda_oe_o   (sda_oe),
		.irq_o      (irq)
	);

	isoa_master_model isoa_master_model_inst (
		.scl_line_i(scl_ln),
		.sda_line_i(sda_ln),
		.scl_pull_o(m_scl),
		.sda_pull_o(m_sda),
		.stall_o   (m_stall)
	);

	// Verdict; a stalled master counts as a mismatch.
	task automatic end_of_test();
		if (m_stall) begin
			n_errors++;
		end
		$display("Checks %0d, errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Compare a seen value against the expected one.
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One-cycle write; the strobe drops at the next edge.
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// One-cycle read; data stand only in the following cycle.
	task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd_reg(a, d);
		chk(d, exp);
	endtask

	// Bounded wait until the device parks the link in its wait state.
	task automatic hold_wait();
		int n;
		n = 0;
		while (scl_oe !== 1'b1 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 5000) begin
			n_errors++;
			end_of_test();
		end
		// The master also pulls the line, so look at the device's own
		// enables a few cycles on: clock still held, data released.
		repeat (4) @(posedge clk);
		#1 chk({6'h00, scl_oe, sda_oe}, 8'h02);
	endtask

	// Watchdog against a hang anywhere in the sequence.
	initial begin
		repeat (100000) @(posedge clk);
		n_errors++;
		end_of_test();
	end

	// Main sequence: registers, a write, a read and a missed address.
	initial begin
		logic [7:0] own;
		logic [7:0] d;
		logic [7:0] v;
		logic       ack;
		v = 8'($urandom(71885));
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		rchk(OFS_SHIFT_DATA, RST_SHIFT_DATA);
		rchk(OFS_OWN_ADDR, RST_OWN_ADDR);
		rchk(OFS_IRQ_MASK, RST_IRQ_MASK);
		wr_reg(16'hFFB0, 8'h5A);
		rchk(16'hFFB0, 8'h00);
		// Bit zero must drop whatever software writes there.
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? 8'hFF : (i == 1) ? 8'h01 : 8'($urandom);
			wr_reg(OFS_OWN_ADDR, v);
			rchk(OFS_OWN_ADDR, v & 8'hFE);
		end
		own = 8'($urandom) & 8'hFE;
		wr_reg(OFS_OWN_ADDR, own);
		// Master writes three bytes; the interrupt starts masked.
		isoa_master_model_inst.start_c();
		isoa_master_model_inst.wr_byte(own, ack);
		chk({7'h00, ack}, 8'h01);
		hold_wait();
		chk({7'h00, irq}, 8'h00);
		rd_reg(OFS_FLAGS, v);
		chk(v & 8'h0E, 8'h0A);
		rchk(OFS_SHIFT_DATA, own);
		wr_reg(OFS_IRQ_MASK, 8'hFF);
		@(posedge clk);
		#1 chk({7'h00, irq}, 8'h01);
		rchk(OFS_IRQ_STATUS, 8'h0B);
		@(posedge clk);
		#1 chk({7'h00, irq}, 8'h00);
		for (int k = 0; k < 3; k++) begin
			d = (k == 0) ? 8'hFF : 8'($urandom);
			fork
				isoa_master_model_inst.wr_byte(d, ack);
				begin
					wr_reg(OFS_CONTROL, 8'h01);
					repeat (100) @(posedge clk);
					// Mid-byte write must be ignored.
					wr_reg(OFS_SHIFT_DATA, ~d);
				end
			join
			chk({7'h00, ack}, 8'h01);
			hold_wait();
			rchk(OFS_SHIFT_DATA, d);
		end
		fork
			isoa_master_model_inst.stop_c();
			wr_reg(OFS_CONTROL, 8'h01);
		join
		repeat (20) @(posedge clk);
		rchk(OFS_IRQ_STATUS, 8'h05);
		rchk(OFS_IRQ_STATUS, 8'h00);
		rchk(OFS_FLAGS, 8'h00);
		// Master reads two bytes and refuses the second one.
		isoa_master_model_inst.start_c();
		isoa_master_model_inst.wr_byte(own | 8'h01, ack);
		chk({7'h00, ack}, 8'h01);
		hold_wait();
		rd_reg(OFS_FLAGS, v);
		chk(v & 8'h0E, 8'h0E);
		// Cancel bit must not end a transmit wait.
		wr_reg(OFS_CONTROL, 8'h01);
		repeat (8) @(posedge clk);
		#1 chk({7'h00, scl_oe}, 8'h01);
		for (int k = 0; k < 2; k++) begin
			d = (k == 0) ? 8'h80 : 8'($urandom);
			fork
				isoa_master_model_inst.rd_byte(v, k == 0);
				begin
					if (k > 0) begin
						hold_wait();
					end
					wr_reg(OFS_SHIFT_DATA, d);
				end
			join
			chk(v, d);
		end
		repeat (60) @(posedge clk);
		#1 chk({7'h00, scl_oe}, 8'h00);
		isoa_master_model_inst.stop_c();
		repeat (20) @(posedge clk);
		#1 chk({7'h00, irq}, 8'h01);
		rchk(OFS_IRQ_STATUS, 8'h0F);
		// Stop interrupt seen: one preload write outside a wait is fine.
		d = 8'($urandom);
		wr_reg(OFS_SHIFT_DATA, d);
		rchk(OFS_SHIFT_DATA, d);
		// A preload must not touch the bus; only a wait write releases.
		chk({6'h00, scl_oe, sda_oe}, 8'h00);
		// Another slave's address leaves this one silent.
		isoa_master_model_inst.start_c();
		isoa_master_model_inst.wr_byte(own ^ 8'h02, ack);
		chk({7'h00, ack}, 8'h00);
		rd_reg(OFS_FLAGS, v);
		chk(v & 8'h0E, 8'h00);
		isoa_master_model_inst.stop_c();
		// Reset in mid-run must clear both registers and the interrupt.
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		rchk(OFS_SHIFT_DATA, RST_SHIFT_DATA);
		rchk(OFS_OWN_ADDR, RST_OWN_ADDR);
		rchk(OFS_IRQ_MASK, RST_IRQ_MASK);
		chk({7'h00, irq}, 8'h00);
		end_of_test();
	end
endmodule

// ==== isoa_master_model.sv ====
// Two-wire bus master model that stands on the far side of the link.
`timescale 1ns/100ps
module isoa_master_model (
	input  wire logic scl_line_i, // Resolved clock line.
	input  wire logic sda_line_i, // Resolved data line.
	output logic      scl_pull_o, // High pulls the clock low.
	output logic      sda_pull_o, // High pulls the data low.
	output logic      stall_o     // Clock stretch ran too long.
);
	// Both lines released; the pull-ups hold them high.
	initial begin
		scl_pull_o = 1'b0;
		sda_pull_o = 1'b0;
		stall_o    = 1'b0;
	end

	// Release the clock and wait while the slave stretches it.
	// The wait is bounded so a stuck slave cannot hang the run.
	task automatic rel_scl();
		int n;
		scl_pull_o = 1'b0;
		n = 0;
		while (scl_line_i !== 1'b1 && n < 5000) begin
			#4;
			n++;
		end
		if (n >= 5000) begin
			stall_o = 1'b1;
		end
	endtask

	// Send one bit; data only changes while the clock is low.
	task automatic put_bit(input logic b);
		sda_pull_o = ~b;
		#40;
		rel_scl();
		#80;
		scl_pull_o = 1'b1;
		#40;
	endtask

	// Take one bit in the middle of the high phase.
	task automatic get_bit(output logic b);
		sda_pull_o = 1'b0;
		#40;
		rel_scl();
		#40;
		b = sda_line_i;
		#40;
		scl_pull_o = 1'b1;
		#40;
	endtask

	// Start: data falls while the clock is high.
	task automatic start_c();
		sda_pull_o = 1'b1;
		#80;
		scl_pull_o = 1'b1;
		#40;
	endtask

	// Stop: data rises while the clock is high.
	task automatic stop_c();
		sda_pull_o = 1'b1;
		#40;
		rel_scl();
		#80;
		sda_pull_o = 1'b0;
		#80;
	endtask

	// Byte out, most significant bit first, then the slave's answer.
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			put_bit(d[i]);
		end
		get_bit(a);
		ack = ~a;
	endtask

	// Byte in, most significant bit first, then our acknowledge.
	task automatic rd_byte(output logic [7:0] d, input logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			get_bit(b);
			d[i] = b;
		end
		put_bit(~ack);
	endtask
endmodule

// ==== isoa_pin_sync.sv ====
// Pin synchroniser and bus condition detector for the two-wire link.
`timescale 1ns/100ps
module isoa_pin_sync (
	input  wire logic sys_clk_i,   // System clock.
	input  wire logic rst_n_i,     // Asynchronous reset, active low.
	input  wire logic scl_i,       // Raw serial clock pin.
	input  wire logic sda_i,       // Raw serial data pin.
	output logic      scl_lvl_o,   // Synchronised clock level.
	output logic      sda_lvl_o,   // Synchronised data level.
	output logic      scl_rise_o,  // Clock rising edge pulse.
	output logic      scl_fall_o,  // Clock falling edge pulse.
	output logic      start_o,     // Start condition pulse.
	output logic      stop_o       // Stop condition pulse.
);
	// Three stages per pin: two to settle, one to find edges.
	logic [2:0] scl_reg;           // Clock pipeline.
	logic [2:0] scl_next;          // Next clock pipeline.
	logic [2:0] sda_reg;           // Data pipeline.
	logic [2:0] sda_next;          // Next data pipeline.

	// Shift the pins in; stage 0 is only read by stage 1.
	always_comb begin
		scl_next = {scl_reg[1:0], scl_i};
		sda_next = {sda_reg[1:0], sda_i};
	end

	// Idle bus is high, so the pipelines reset high to avoid false edges.
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_reg <= 3'h7;
			sda_reg <= 3'h7;
		end else begin
			scl_reg <= scl_next;
			sda_reg <= sda_next;
		end
	end

	// Edges compare the settled stage with the one after it.
	assign scl_lvl_o  = scl_reg[1];
	assign sda_lvl_o  = sda_reg[1];
	assign scl_rise_o = scl_reg[1] & ~scl_reg[2];
	assign scl_fall_o = ~scl_reg[1] & scl_reg[2];
	// Data moving while the clock stays high marks a bus condition.
	assign start_o = scl_reg[1] & scl_reg[2] & ~sda_reg[1] & sda_reg[2];
	assign stop_o  = scl_reg[1] & scl_reg[2] & sda_reg[1] & ~sda_reg[2];

endmodule

// ==== isoa_pkg.sv ====
// Shared constants for the two-wire shift-data and own-address block.
package isoa_pkg;

	// Register port geometry.
	localparam int          REG_ADDR_W = 16;               // Address width.
	localparam int          REG_DATA_W = 8;                // Data width.

	// Register offsets on the plain register port.
	localparam logic [15:0] OFS_SHIFT_DATA = 16'hFFA5;     // Byte shifter.
	localparam logic [15:0] OFS_OWN_ADDR   = 16'hFFA6;     // Own address.
	localparam logic [15:0] OFS_CONTROL    = 16'hFFA7;     // Control bits.
	localparam logic [15:0] OFS_IRQ_STATUS = 16'hFFA8;     // Sticky events.
	localparam logic [15:0] OFS_IRQ_MASK   = 16'hFFA9;     // Event mask.
	localparam logic [15:0] OFS_FLAGS      = 16'hFFAA;     // Live flags.

	// Reset values.
	localparam logic [7:0]  RST_SHIFT_DATA = 8'h00;        // Shifter.
	localparam logic [7:0]  RST_OWN_ADDR   = 8'h00;        // Own address.
	localparam logic [7:0]  RST_IRQ_MASK   = 8'h00;        // Mask.
	localparam logic [7:0]  RST_IRQ_STATUS = 8'h00;        // Status.

	// Control register fields.
	localparam int          CTL_WAIT_CANCEL_BIT = 0;       // Write one.

	// Interrupt status and mask fields.
	localparam int          IRQ_BYTE_DONE = 0;             // Wait entered.
	localparam int          IRQ_START     = 1;             // Start seen.
	localparam int          IRQ_STOP      = 2;             // Stop seen.
	localparam int          IRQ_MATCH     = 3;             // Address hit.

	// Live flag register fields.
	localparam int          FLG_START_DETECTED  = 0;       // Start flag.
	localparam int          FLG_ADDRESS_MATCH   = 1;       // Match flag.
	localparam int          FLG_TRANSMIT_STATE  = 2;       // Sending.
	localparam int          FLG_WAIT            = 3;       // Clock held.

	// Bits per byte on the link.
	localparam logic [3:0]  BITS_PER_BYTE = 4'h8;          // Byte length.

	// Byte engine states, one-hot.
	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,                                   // Not addressed.
		ST_SHIFT = 4'h2,                                   // Moving bits.
		ST_ACK   = 4'h4,                                   // Ninth clock.
		ST_WAIT  = 4'h8                                    // Clock held low.
	} isoa_state_t;

endpackage
